//--- rtl/acsp_port.sv
// Serial configuration port of a dual-core converter, slave side.
// Assumes async serial pins and a serial clock
// well below clk/4, so the sampler sees every level.
//
// Contract
// - Shared data pin by default; config bit 7 moves read data out.
// - Half-duplex slave; dedicated output stays driven when unselected.
// - Clock low before select falls; first rise then starts instruction.
// - Bit order per config bit 6; address counts up MSB-first, down LSB.
// - Instruction: read flag, two count bits, thirteen address bits.
// - Count 00..11 means one to four-or-more bytes; runs while selected.
// - Pauses at byte boundaries; long bursts reset on late select rise.
// - Soft reset bit restores defaults except the trim and power-down fields.
// - Burst ends on select rise or at the burst stop address.
// - Converter index picks the core; zero after reset selects none.
// - Indexed read with no core selected answers AD.
// - Offset trims 8-bit, 0x80 is zero offset.
// - Trims load calibration; master reads then writes to adjust.
// - Coarse gain is four additive step bits.
// - Medium and fine gain 8-bit, 0x80 is zero.
// - Power-down codes; nonzero overrides the pin.
// - Power-down per indexed core; soft reset keeps it.
// - Global skew trim resets to 00h, 0x80 means no skew.
`timescale 1ns/10ps
module acsp_port #(
    parameter logic [7:0] DIE_ID  = 8'h5A, // Arbitrary value
    parameter logic [7:0] DIE_REV = 8'h01  // Arbitrary value
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     clk_en,
    input  wire logic                     sclk,
    input  wire logic                     select_n,
    input  wire logic                     sdio_i,
    output logic                          sdio_o,
    output logic                          sdio_oe,
    output logic                          dedicated_read_out,
    input  wire acsp_pkg::acsp_mode_t     power_mode_pin,
    input  wire logic                     cal_load,
    input  wire logic                     cal_core,
    input  wire acsp_pkg::acsp_trim_t     cal_trim,
    output acsp_pkg::acsp_trim_t [1:0]    core_trim,
    output acsp_pkg::acsp_mode_t [1:0]    core_mode,
    output logic                 [7:0]    skew_trim
);
    localparam int AW = acsp_pkg::ADDR_W;

    acsp_pkg::acsp_pins_t  pins_s;
    acsp_pkg::acsp_state_t state_q;
    acsp_pkg::acsp_instr_t instr_next;

    logic          sclk_prev_q;
    logic          rise;
    logic          fall;
    logic          sel_n;
    logic          cfg_four_q;
    logic          cfg_lsb_q;
    logic [7:0]    burst_stop_q;
    logic [7:0]    conv_sel_q;
    logic [15:0]   instr_sr_q;
    logic [3:0]    bit_cnt_q;
    logic [1:0]    cnt_q;
    logic          rd_q;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_nxt;
    logic [1:0]    bytes_done_q;
    logic [7:0]    rx_sr_q;
    logic [7:0]    rx_next;
    logic [7:0]    tx_q;
    logic          byte_done;
    logic          last_byte;
    logic          pause_ok;
    logic          wr_fire;
    logic          soft_rst;
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_byte;
    logic [7:0]    core_rd [2];
    logic [1:0]    core_wr;
    logic          indexed_rd;

    // Next address in bit order
    function automatic logic [AW-1:0] step_addr(
        input logic [AW-1:0] a,
        input logic          lsb_first
    );
        step_addr = lsb_first ? AW'(a - 1'b1) : AW'(a + 1'b1);
    endfunction : step_addr

    // Address in the low register page
    function automatic logic in_page(input logic [AW-1:0] a);
        in_page = (a[AW-1:8] == '0);
    endfunction : in_page

    function automatic logic is_indexed(input logic [AW-1:0] a);
        is_indexed = in_page(a) && a[7:0] >= acsp_pkg::REG_OFFS_LARGE
                     && a[7:0] <= acsp_pkg::REG_PWR_CTRL;
    endfunction : is_indexed

    acsp_sync #(
        .W ($bits(acsp_pkg::acsp_pins_t))
    ) u_sync (
        .clk    (clk),
        .nrst   (nrst),
        .clk_en (clk_en),
        .d      ({select_n, sclk, sdio_i, power_mode_pin}),
        .q      (pins_s)
    );

    assign sel_n = pins_s.sel_n;
    assign rise  = pins_s.sclk & ~sclk_prev_q;
    assign fall  = ~pins_s.sclk & sclk_prev_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_q <= 1'b0;
        end else if (clk_en) begin
            sclk_prev_q <= pins_s.sclk;
        end
    end

    // Incoming bit enters at the bit-order end
    always_comb begin
        instr_next = cfg_lsb_q ? {pins_s.sdio, instr_sr_q[15:1]}
                               : {instr_sr_q[14:0], pins_s.sdio};
        rx_next    = cfg_lsb_q ? {pins_s.sdio, rx_sr_q[7:1]}
                               : {rx_sr_q[6:0], pins_s.sdio};
    end

    assign addr_nxt  = step_addr(addr_q, cfg_lsb_q);
    assign byte_done = (state_q == acsp_pkg::ACSP_ST_DATA) && !sel_n
                       && rise && bit_cnt_q[2:0] == acsp_pkg::DATA_LAST_BIT;

    // Fixed counts stop after their byte; bursts stop at the stop address
    always_comb begin
        if (cnt_q != acsp_pkg::CNT_BURST) begin
            last_byte = (bytes_done_q == cnt_q);
        end else begin
            last_byte = in_page(addr_q)
                        && addr_q[7:0] == burst_stop_q;
        end
    end

    // Deselect pauses only at legal boundaries
    always_comb begin
        pause_ok = 1'b0;
        if (state_q == acsp_pkg::ACSP_ST_INSTR) begin
            pause_ok = (bit_cnt_q[2:0] == 3'h0);
        end else if (state_q == acsp_pkg::ACSP_ST_DATA) begin
            pause_ok = (bit_cnt_q == 4'h0)
                       && (bytes_done_q == 2'h0
                           || cnt_q != acsp_pkg::CNT_BURST);
        end
    end

    assign wr_fire  = byte_done && !rd_q && in_page(addr_q);
    assign soft_rst = wr_fire && addr_q[7:0] == acsp_pkg::REG_PORT_CFG
                      && rx_next[acsp_pkg::CFG_SOFT_RST_BIT];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q      <= acsp_pkg::ACSP_ST_IDLE;
            instr_sr_q   <= '0;
            bit_cnt_q    <= 4'h0;
            cnt_q        <= 2'b00;
            rd_q         <= 1'b0;
            addr_q       <= '0;
            bytes_done_q <= 2'h0;
            rx_sr_q      <= 8'h00;
        end else if (clk_en) begin
            unique case (state_q)
                acsp_pkg::ACSP_ST_IDLE: begin
                    if (!sel_n && rise) begin
                        instr_sr_q <= instr_next;
                        bit_cnt_q  <= 4'h1;
                        state_q    <= acsp_pkg::ACSP_ST_INSTR;
                    end
                end
                acsp_pkg::ACSP_ST_INSTR: begin
                    if (sel_n) begin
                        if (!pause_ok) begin
                            state_q <= acsp_pkg::ACSP_ST_IDLE;
                        end
                    end else if (rise) begin
                        instr_sr_q <= instr_next;
                        bit_cnt_q  <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == acsp_pkg::INSTR_LAST_BIT) begin
                            rd_q         <= instr_next.rd;
                            cnt_q        <= instr_next.cnt;
                            addr_q       <= instr_next.addr;
                            bytes_done_q <= 2'h0;
                            bit_cnt_q    <= 4'h0;
                            state_q      <= acsp_pkg::ACSP_ST_DATA;
                        end
                    end
                end
                acsp_pkg::ACSP_ST_DATA: begin
                    if (sel_n) begin
                        if (!pause_ok) begin
                            state_q <= acsp_pkg::ACSP_ST_IDLE;
                        end
                    end else if (rise) begin
                        rx_sr_q   <= rx_next;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (byte_done) begin
                            bit_cnt_q <= 4'h0;
                            if (bytes_done_q != 2'h3) begin
                                bytes_done_q <= bytes_done_q + 2'h1;
                            end
                            if (last_byte) begin
                                state_q <= acsp_pkg::ACSP_ST_IDLE;
                            end else begin
                                addr_q <= addr_nxt;
                            end
                        end
                    end
                end
                default: state_q <= acsp_pkg::ACSP_ST_IDLE;
            endcase
        end
    end

    // Low nibble is never stored, only mirrored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_four_q <= 1'b0;
            cfg_lsb_q  <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst) begin
                cfg_four_q <= 1'b0;
                cfg_lsb_q  <= 1'b0;
            end else if (wr_fire
                         && addr_q[7:0] == acsp_pkg::REG_PORT_CFG) begin
                cfg_four_q <= rx_next[acsp_pkg::CFG_FOUR_WIRE_BIT];
                cfg_lsb_q  <= rx_next[acsp_pkg::CFG_LSB_FIRST_BIT];
            end
        end
    end

    // Global registers that soft reset restores
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            burst_stop_q <= acsp_pkg::RST_BURST_STOP;
            conv_sel_q   <= acsp_pkg::RST_CONV_SEL;
            skew_trim    <= acsp_pkg::RST_SKEW;
        end else if (clk_en) begin
            if (soft_rst) begin
                burst_stop_q <= acsp_pkg::RST_BURST_STOP;
                conv_sel_q   <= acsp_pkg::RST_CONV_SEL;
                skew_trim    <= acsp_pkg::RST_SKEW;
            end else if (wr_fire) begin
                unique case (addr_q[7:0])
                    acsp_pkg::REG_BURST_STOP: burst_stop_q <= rx_next;
                    acsp_pkg::REG_CONV_SEL:   conv_sel_q   <= rx_next;
                    acsp_pkg::REG_SKEW:       skew_trim    <= rx_next;
                    default: ;
                endcase
            end
        end
    end

    // Indexed writes reach only indexed cores
    always_comb begin
        core_wr[0] = wr_fire && is_indexed(addr_q)
                     && conv_sel_q[acsp_pkg::SEL_CORE_A_BIT];
        core_wr[1] = wr_fire && is_indexed(addr_q)
                     && conv_sel_q[acsp_pkg::SEL_CORE_B_BIT];
    end

    for (genvar c = 0; c < 2; c++) begin : g_core
        acsp_core_trim u_core (
            .clk      (clk),
            .nrst     (nrst),
            .clk_en   (clk_en),
            .wr_en    (core_wr[c]),
            .wr_addr  (addr_q[7:0]),
            .wr_data  (rx_next),
            .cal_load (cal_load && cal_core == 1'(c)),
            .cal_trim (cal_trim),
            .pin_mode (pins_s.mode_pin),
            .rd_addr  (rd_addr[7:0]),
            .rd_data  (core_rd[c]),
            .trim     (core_trim[c]),
            .mode     (core_mode[c])
        );
    end

    // Read address: fresh instruction's, else the next
    assign rd_addr    = (state_q == acsp_pkg::ACSP_ST_INSTR)
                        ? instr_next.addr : addr_nxt;
    assign indexed_rd = is_indexed(rd_addr);

    always_comb begin
        rd_byte = acsp_pkg::RD_UNMAPPED;
        if (indexed_rd) begin
            if (conv_sel_q[acsp_pkg::SEL_CORE_A_BIT]) begin
                rd_byte = core_rd[0];
            end else if (conv_sel_q[acsp_pkg::SEL_CORE_B_BIT]) begin
                rd_byte = core_rd[1];
            end else begin
                rd_byte = acsp_pkg::ERR_NO_CORE;
            end
        end else if (in_page(rd_addr)) begin
            unique case (rd_addr[7:0])
                acsp_pkg::REG_PORT_CFG: begin
                    rd_byte = {cfg_four_q, cfg_lsb_q, 2'b01,
                               2'b10, cfg_lsb_q, cfg_four_q};
                end
                acsp_pkg::REG_BURST_STOP: rd_byte = burst_stop_q;
                acsp_pkg::REG_DIE_ID:     rd_byte = DIE_ID;
                acsp_pkg::REG_DIE_REV:    rd_byte = DIE_REV;
                acsp_pkg::REG_CONV_SEL:   rd_byte = conv_sel_q;
                acsp_pkg::REG_SKEW:       rd_byte = skew_trim;
                default:                  rd_byte = acsp_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // Load at the rise ending a byte, shift on falls
    // so the master samples on rise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_q               <= 8'h00;
            sdio_o             <= 1'b0;
            dedicated_read_out <= 1'b0;
        end else if (clk_en && !sel_n) begin
            if (state_q == acsp_pkg::ACSP_ST_INSTR && rise
                && bit_cnt_q == acsp_pkg::INSTR_LAST_BIT) begin
                tx_q <= rd_byte;
            end else if (byte_done && rd_q && !last_byte) begin
                tx_q <= rd_byte;
            end else if (state_q == acsp_pkg::ACSP_ST_DATA && rd_q && fall) begin
                sdio_o             <= cfg_lsb_q ? tx_q[0] : tx_q[7];
                dedicated_read_out <= cfg_lsb_q ? tx_q[0] : tx_q[7];
                tx_q <= cfg_lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
            end
        end
    end

    // Shared pin taken only in three-wire reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdio_oe <= 1'b0;
        end else if (clk_en) begin
            if (sel_n || cfg_four_q) begin
                sdio_oe <= 1'b0;
            end else if (state_q == acsp_pkg::ACSP_ST_DATA && rd_q && fall) begin
                sdio_oe <= 1'b1;
            end
        end
    end
endmodule : acsp_port

//--- rtl/acsp_pkg.sv
// Constants and types of the converter serial port.
// Assumes one 100 MHz clock samples every port pin.
package acsp_pkg;
    localparam int ADDR_W = 13;

    // Register offsets
    localparam logic [7:0] REG_PORT_CFG   = 8'h00;
    localparam logic [7:0] REG_BURST_STOP = 8'h02;
    localparam logic [7:0] REG_DIE_ID     = 8'h08;
    localparam logic [7:0] REG_DIE_REV    = 8'h09;
    localparam logic [7:0] REG_CONV_SEL   = 8'h10;
    localparam logic [7:0] REG_OFFS_LARGE = 8'h20;
    localparam logic [7:0] REG_OFFS_SMALL = 8'h21;
    localparam logic [7:0] REG_GAIN_LARGE = 8'h22;
    localparam logic [7:0] REG_GAIN_MID   = 8'h23;
    localparam logic [7:0] REG_GAIN_SMALL = 8'h24;
    localparam logic [7:0] REG_PWR_CTRL   = 8'h25;
    localparam logic [7:0] REG_SKEW       = 8'h70;

    // Port configuration and converter select fields
    localparam int CFG_FOUR_WIRE_BIT = 7;
    localparam int CFG_LSB_FIRST_BIT = 6;
    localparam int CFG_SOFT_RST_BIT  = 5;
    localparam int SEL_CORE_A_BIT    = 0;
    localparam int SEL_CORE_B_BIT    = 1;

    // Reset values, fixed answers and protocol counts
    localparam logic [7:0] RST_BURST_STOP = 8'h00;
    localparam logic [7:0] RST_CONV_SEL   = 8'h00;
    localparam logic [7:0] RST_SKEW       = 8'h00;
    localparam logic [7:0] RST_TRIM_MID   = 8'h80;
    localparam logic [3:0] RST_GAIN_LARGE = 4'h0;
    localparam logic [7:0] ERR_NO_CORE    = 8'hAD;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;
    localparam logic [1:0] CNT_BURST      = 2'b11;
    localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
    localparam logic [2:0] DATA_LAST_BIT  = 3'h7;

    // Power-down field codes
    localparam logic [2:0] PWR_PIN    = 3'b000;
    localparam logic [2:0] PWR_NORMAL = 3'b001;
    localparam logic [2:0] PWR_NAP    = 3'b010;
    localparam logic [2:0] PWR_SLEEP  = 3'b100;

    typedef enum logic [1:0] {
        ACSP_MODE_NORMAL = 2'b00,
        ACSP_MODE_NAP    = 2'b01,
        ACSP_MODE_SLEEP  = 2'b10
    } acsp_mode_t;

    typedef enum logic [1:0] {
        ACSP_ST_IDLE  = 2'b00,
        ACSP_ST_INSTR = 2'b01,
        ACSP_ST_DATA  = 2'b10
    } acsp_state_t;

    typedef struct packed {
        logic              rd;
        logic [1:0]        cnt;
        logic [ADDR_W-1:0] addr;
    } acsp_instr_t;

    typedef struct packed {
        logic [7:0] offs_large;
        logic [7:0] offs_small;
        logic [3:0] gain_large;
        logic [7:0] gain_mid;
        logic [7:0] gain_small;
    } acsp_trim_t;

    typedef struct packed {
        logic       sel_n;
        logic       sclk;
        logic       sdio;
        acsp_mode_t mode_pin;
    } acsp_pins_t;
endpackage : acsp_pkg

//--- rtl/acsp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes independent bit levels; no word coherence.
`timescale 1ns/10ps
module acsp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q      <= '0;
        end else if (clk_en) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : acsp_sync

//--- rtl/acsp_core_trim.sv
// Per-core trim and power-down store, one instance per converter core.
// Assumes the port qualifies writes by the index.
`timescale 1ns/10ps
module acsp_core_trim (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                clk_en,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wr_addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic                cal_load,
    input  wire acsp_pkg::acsp_trim_t cal_trim,
    input  wire acsp_pkg::acsp_mode_t pin_mode,
    input  wire logic [7:0]          rd_addr,
    output logic      [7:0]          rd_data,
    output acsp_pkg::acsp_trim_t     trim,
    output acsp_pkg::acsp_mode_t     mode
);
    logic [2:0] pwr_q;

    // Trims start mid-scale, coarse gain at zero, until calibration lands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trim <= '{acsp_pkg::RST_TRIM_MID, acsp_pkg::RST_TRIM_MID,
                      acsp_pkg::RST_GAIN_LARGE, acsp_pkg::RST_TRIM_MID,
                      acsp_pkg::RST_TRIM_MID};
        end else if (clk_en) begin
            if (cal_load) begin
                trim <= cal_trim;
            end else if (wr_en) begin
                unique case (wr_addr)
                    acsp_pkg::REG_OFFS_LARGE: trim.offs_large <= wr_data;
                    acsp_pkg::REG_OFFS_SMALL: trim.offs_small <= wr_data;
                    acsp_pkg::REG_GAIN_LARGE: trim.gain_large <= wr_data[3:0];
                    acsp_pkg::REG_GAIN_MID:   trim.gain_mid   <= wr_data;
                    acsp_pkg::REG_GAIN_SMALL: trim.gain_small <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    // Power-down field; soft reset never reaches it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_q <= acsp_pkg::PWR_PIN;
        end else if (clk_en && wr_en && wr_addr == acsp_pkg::REG_PWR_CTRL) begin
            pwr_q <= wr_data[2:0];
        end
    end

    // Any nonzero field overrides the shared pin for this core only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode <= acsp_pkg::ACSP_MODE_NORMAL;
        end else if (clk_en) begin
            unique case (pwr_q)
                acsp_pkg::PWR_PIN:   mode <= pin_mode;
                acsp_pkg::PWR_NAP:   mode <= acsp_pkg::ACSP_MODE_NAP;
                acsp_pkg::PWR_SLEEP: mode <= acsp_pkg::ACSP_MODE_SLEEP;
                default:             mode <= acsp_pkg::ACSP_MODE_NORMAL;
            endcase
        end
    end

    always_comb begin
        unique case (rd_addr)
            acsp_pkg::REG_OFFS_LARGE: rd_data = trim.offs_large;
            acsp_pkg::REG_OFFS_SMALL: rd_data = trim.offs_small;
            acsp_pkg::REG_GAIN_LARGE: rd_data = {4'h0, trim.gain_large};
            acsp_pkg::REG_GAIN_MID:   rd_data = trim.gain_mid;
            acsp_pkg::REG_GAIN_SMALL: rd_data = trim.gain_small;
            acsp_pkg::REG_PWR_CTRL:   rd_data = {5'h00, pwr_q};
            default:                  rd_data = acsp_pkg::RD_UNMAPPED;
        endcase
    end
endmodule : acsp_core_trim

//--- verification/acsp_spi_master.sv
// Serial master model, clock idles low.
// Assumes clk is the bench clock; half period 4 clk.
`timescale 1ns/10ps
module acsp_spi_master (
    input  wire logic clk,
    input  wire logic miso,
    output logic      sclk,
    output logic      select_n,
    output logic      mosi,
    output logic      m_oe
);
    initial {sclk, select_n, mosi, m_oe} = 4'b0100;
    task automatic bits(input logic [15:0] v, input int n,
                        input logic lsb, output logic [15:0] rx);
        rx = '0;
        for (int i = 0; i < n; i++) begin
            int k = lsb ? i : n - 1 - i;
            mosi = v[k];
            repeat (4) @(negedge clk); // 80 ns period, kept for reads
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            rx[k] = miso; // Late: covers sync latency
            sclk = 1'b0;
        end
    endtask : bits
    task automatic xfer(input logic rd, input logic lsb,
                        input logic [12:0] a, input int n,
                        input logic [31:0] w, output logic [31:0] r);
        logic [15:0] d;
        r = '0;
        select_n = 1'b0; // Clock already low
        m_oe = 1'b1;
        repeat (4) @(negedge clk);
        bits({rd, n > 3 ? 2'b11 : 2'(n - 1), a}, 16, lsb, d);
        m_oe = !rd;
        for (int b = 0; b < n; b++) begin
            bits({8'h00, w[31-8*b -: 8]}, 8, lsb, d);
            r[31-8*b -: 8] = d[7:0];
        end
        repeat (4) @(negedge clk);
        select_n = 1'b1; // Ends a long burst
        m_oe = 1'b0;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : acsp_spi_master

//--- verification/acsp_port_assertions.sv
// Checks on the serial port outputs.
// Assumes serial half periods of 4 clk or more.
`timescale 1ns/10ps
module acsp_port_assertions (
    input wire logic                       clk,
    input wire logic                       nrst,
    input wire logic                       clk_en,
    input wire logic                       select_n,
    input wire logic                       sdio_oe,
    input wire logic                       cal_load,
    input wire logic                       cal_core,
    input wire acsp_pkg::acsp_mode_t       power_mode_pin,
    input wire acsp_pkg::acsp_trim_t       cal_trim,
    input wire acsp_pkg::acsp_trim_t [1:0] core_trim,
    input wire acsp_pkg::acsp_mode_t [1:0] core_mode,
    input wire logic [7:0]                 skew_trim
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence idle_s; select_n [*6]; endsequence
    sequence load_s(c); clk_en && cal_load && cal_core == c; endsequence
    a_oe_released: assert property (idle_s |-> !sdio_oe)
        else $error("pin driven deselected");
    a_oe_selected: assert property ($rose(sdio_oe) |-> !select_n)
        else $error("pin taken unselected");
    a_cal_core_a: assert property (load_s(1'b0) |=>
        core_trim[0] == $past(cal_trim) && $stable(core_trim[1]))
        else $error("core A cal load");
    a_cal_core_b: assert property (load_s(1'b1) |=>
        core_trim[1] == $past(cal_trim) && $stable(core_trim[0]))
        else $error("core B cal load");
    a_trims_held: assert property (idle_s ##0 !cal_load |=>
        $stable(core_trim)) else $error("trims moved idle");
    a_skew_held: assert property (idle_s |=> $stable(skew_trim))
        else $error("skew moved idle");
    a_modes_held: assert property (idle_s and
        $stable(power_mode_pin) [*6] |=> $stable(core_mode))
        else $error("mode moved idle");
    a_reset_vals: assert property ($rose(nrst) |->
        skew_trim == 8'h00 && core_trim[1].gain_mid == 8'h80 && !sdio_oe)
        else $error("bad reset values");
endmodule : acsp_port_assertions
bind acsp_port acsp_port_assertions u_chk (.*);

//--- verification/tb.sv
// Self-checking bench for the serial port.
// Assumes the master model and bound checker.
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] ID  = 8'hC3; // Arbitrary value
    localparam logic [7:0] REV = 8'h2E; // Arbitrary value
    logic                       clk, nrst, cal_load, cal_core, fw, lsb;
    logic                       sclk, select_n, mosi, m_oe, so, soe, dro;
    logic [7:0]                 skew, e, seen, q[$];
    logic [31:0]                w, r;
    logic [2:0]                 c;
    acsp_pkg::acsp_mode_t       pin;
    acsp_pkg::acsp_trim_t       cal_trim;
    acsp_pkg::acsp_trim_t [1:0] ct, cal;
    acsp_pkg::acsp_mode_t [1:0] cm;
    wire                        sdio_w, miso;
    string                      what;
    event                       ev;
    int                         failures = 0;
    int                         n_checks = 0;
    // Released line shows inverse of last value
    assign sdio_w = soe ? so : (m_oe ? mosi : ~mosi);
    assign miso = fw ? dro : sdio_w;
    acsp_spi_master m (.clk(clk), .miso(miso), .sclk(sclk),
        .select_n(select_n), .mosi(mosi), .m_oe(m_oe));
    acsp_port #(.DIE_ID(ID), .DIE_REV(REV)) dut (.clk(clk), .nrst(nrst),
        .clk_en(1'b1), .sclk(sclk), .select_n(select_n), .sdio_i(sdio_w),
        .sdio_o(so), .sdio_oe(soe), .dedicated_read_out(dro),
        .power_mode_pin(pin), .cal_load(cal_load), .cal_core(cal_core),
        .cal_trim(cal_trim), .core_trim(ct), .core_mode(cm),
        .skew_trim(skew));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
    always @(ev) begin
        e = q.pop_front();
        n_checks++;
        if (e !== seen) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, seen);
        end
    end
    task automatic note(input string s, input logic [7:0] x, v);
        q.push_back(x);
        what = s;
        seen = v;
        ->ev;
        #1;
    endtask : note
    task automatic wr(input logic [12:0] a, input int n, input logic [31:0] d);
        m.xfer(1'b0, lsb, a, n, d, r);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] x, string s);
        m.xfer(1'b1, lsb, a, 1, 32'h0, r);
        note(s, x, r[31:24]);
    endtask : rd
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        void'($urandom(1));
        {nrst, cal_load, cal_core, fw, lsb, cal_trim} = '0;
        pin = acsp_pkg::acsp_mode_t'($urandom_range(2));
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 2; k++) begin
            cal[k] = 36'({$urandom(), $urandom()});
            {cal_core, cal_trim, cal_load} = {k[0], cal[k], 1'b1};
            @(negedge clk);
            cal_load = 1'b0;
            @(negedge clk);
        end
        rd(13'h008, ID, "id");
        rd(13'h009, REV, "rev");
        rd(13'h020, 8'hAD, "no_core");
        rd(13'h005, 8'h00, "unmapped");
        wr(13'h010, 1, 32'h0100_0000);
        w = $urandom();
        wr(13'h020, 4, w);
        note("offs_l", w[31:24], ct[0].offs_large);
        note("offs_s", w[23:16], ct[0].offs_small);
        note("gain_l", w[11:8], ct[0].gain_large);
        note("gain_m", w[7:0], ct[0].gain_mid);
        note("core_b", cal[1].offs_large, ct[1].offs_large);
        w = $urandom();
        wr(13'h070, 1, w);
        note("skew", w[31:24], skew);
        for (int i = 0; i < 4; i++) begin
            c = i == 0 ? 3'b000 : 3'(1 << (i - 1));
            wr(13'h025, 1, {5'h0, c, 24'h0});
            note("mode_a", i == 0 ? pin : 8'(i - 1), cm[0]);
            note("mode_b", pin, cm[1]);
        end
        wr(13'h000, 1, 32'h5A00_0000);
        lsb = 1'b1;
        w = $urandom();
        wr(13'h021, 2, w);
        note("lsb_s", w[31:24], ct[0].offs_small);
        note("lsb_l", w[23:16], ct[0].offs_large);
        rd(13'h008, ID, "lsb_id");
        wr(13'h000, 1, 32'h9900_0000);
        {lsb, fw} = 2'b01;
        rd(13'h009, REV, "dro_rev");
        wr(13'h000, 1, 32'h3C00_0000);
        fw = 1'b0;
        note("skew_rst", 8'h00, skew);
        note("mode_kept", 8'h02, cm[0]);
        rd(13'h020, 8'hAD, "idx_rst");
        tally_and_finish();
    end
endmodule : tb
